// >>> design/adcc_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Offsets are chosen locally; no offsets exist for these registers
package adcc_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_RES_LOW = 8'h00;
   localparam logic [7:0] OFF_RES_HIGH = 8'h04;
   localparam logic [7:0] OFF_CTRL_A = 8'h08;
   localparam logic [7:0] OFF_CTRL_B = 8'h0c;
   localparam logic [7:0] OFF_PIN_SEL_A = 8'h10;
   localparam logic [7:0] OFF_PIN_SEL_B = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
   localparam logic [7:0] OFF_SIM_RES = 8'h20;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int CA_START = 7;
   localparam int CA_BUSY = 6;
   localparam int CA_PDN = 5;
   localparam int CB_BGEN = 6;
   localparam int CB_JUST = 5;
   localparam logic [7:0] CTRL_A_RST = 8'h60;
   localparam logic [6:0] CTRL_B_RST = 7'h00;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CONV_CLKS = 16;
   localparam int SUB_DIV = 8;
   localparam int RES_W = 12;

   typedef enum logic [2:0] {
      ADCC_IDLE = 3'b001,
      ADCC_RESET = 3'b010,
      ADCC_CONV = 3'b100
   } adcc_state_t;

   typedef struct packed {
      logic [4:0] chan;
      logic [1:0] vref;
      logic [2:0] clk_sel;
      logic bg_on;
      logic pdn;
   } adcc_analog_t;
endpackage : adcc_pkg

// >>> design/adcc_top.sv
// Purpose: Control, clocking and result registers around a 12-bit ADC
// Assumes: Analog sample value arrives on sample_in as a 12-bit word
// Notes: Conversion length fixed; sub clock is a divided system clock
//
// Contract
// - One shared converter samples the routed input
// - Justify 0: high holds 11..4, low 3..0
// - Justify 1: low holds 7..0, high 11..8
// - Unused result bits always read zero
// - Start high then low launches one conversion
// - Start held high resets converter, busy one
// - Busy reads one during conversion, read-only
// - Power-down bit one switches converter off
// - Channel code routes pins, amplifiers, bandgap
// - Bandgap enable bit turns reference circuit on when it is used and power-down is zero
// - Bandgap off when unused and monitors off
// - Reference select: supply, pin, internal
// - Clock select divides system clock or sub
// - Control B top bit reads zero
// - Pin select makes pin analog, drops pull-up
// - Conversion end sets interrupt request flag
`timescale 1ns/1ps
module adcc_top #(
   parameter int CONV_LEN = adcc_pkg::CONV_CLKS
) (
   input wire logic sys_clk, // 250 MHz clock
   input wire logic rst, // Sync reset, high
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic wb_we_i, // Write enable
   input wire logic [7:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte lanes
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Acknowledge
   input wire logic [11:0] sample_in, // Routed analog sample
   input wire logic lv_monitors_on, // Low-voltage monitors active
   output logic [4:0] input_channel_select, // Mux code
   output logic [10:0] analog_sel_onehot, // Pins 0-7, demod, oc, bg
   output logic [2:0] ref_sel_onehot, // Supply, pin, internal
   output logic converter_power_down, // Converter off
   output logic bandgap_on, // Bandgap circuit powered
   output logic conv_reset, // Converter held in reset
   output logic sample_take, // Sample strobe
   output logic [15:0] pin_analog_mode, // Pin is analog input
   output logic [15:0] pin_pullup_off, // Pull-high removed
   output logic irq // Level interrupt
);
   if (CONV_LEN < 2 || CONV_LEN > 255) begin : g_bad_len
      $error("CONV_LEN out of range");
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic start;
   logic pdn;
   logic [4:0] chan;
   logic [6:0] ctrl_b;
   logic [7:0] pin_sel_a;
   logic [7:0] pin_sel_b;
   logic irq_stat;
   logic irq_mask;
   logic [11:0] result;
   adcc_pkg::adcc_state_t state;
   adcc_pkg::adcc_analog_t ana;
   logic wr_hit;
   logic conv_done;
   logic [7:0] res_low;
   logic [7:0] res_high;
   logic ck_en;
   logic busy;

   assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
      && wb_sel_i[0];

   // Write strobe of one register; shared by stores and checks
   function automatic logic wr_reg(input logic hit, input logic [7:0] adr,
                                   input logic [7:0] off);
      return hit && adr == off;
   endfunction : wr_reg

   // Ack term in the request stops a second write in the ack cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   // Busy flag is not stored: writes to its position are dropped
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         start <= adcc_pkg::CTRL_A_RST[adcc_pkg::CA_START];
         pdn <= adcc_pkg::CTRL_A_RST[adcc_pkg::CA_PDN];
         chan <= adcc_pkg::CTRL_A_RST[4:0];
      end else if (wr_reg(wr_hit, wb_adr_i, adcc_pkg::OFF_CTRL_A)) begin
         start <= wb_dat_i[adcc_pkg::CA_START];
         pdn <= wb_dat_i[adcc_pkg::CA_PDN];
         chan <= wb_dat_i[4:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_b <= adcc_pkg::CTRL_B_RST;
         pin_sel_a <= 8'h00;
         pin_sel_b <= 8'h00;
         irq_mask <= 1'b0;
      end else if (wr_hit) begin
         case (wb_adr_i)
            adcc_pkg::OFF_CTRL_B: ctrl_b <= wb_dat_i[6:0];
            adcc_pkg::OFF_PIN_SEL_A: pin_sel_a <= wb_dat_i[7:0];
            adcc_pkg::OFF_PIN_SEL_B: pin_sel_b <= wb_dat_i[7:0];
            adcc_pkg::OFF_IRQ_MASK: irq_mask <= wb_dat_i[0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Conversion clock divider
   // ---------------------------------------------------------------
   logic [6:0] div_cnt;
   logic [2:0] sub_cnt;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_cnt <= 7'h00;
         sub_cnt <= 3'h0;
      end else begin
         div_cnt <= div_cnt + 7'h01;
         sub_cnt <= sub_cnt + 3'h1;
      end
   end

   // Divide by 2^code; code 7 uses the sub clock stand-in
   always_comb begin
      if (ctrl_b[2:0] == 3'h7) begin
         ck_en = (sub_cnt == 3'h7);
      end else begin
         ck_en = ((div_cnt & ((7'h01 << ctrl_b[2:0]) - 7'h01)) == 7'h00);
      end
   end

   // ---------------------------------------------------------------
   // Conversion sequencer
   // ---------------------------------------------------------------
   logic [7:0] conv_cnt;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= adcc_pkg::ADCC_IDLE;
         conv_cnt <= 8'h00;
      end else if (start) begin
         state <= adcc_pkg::ADCC_RESET;
         conv_cnt <= 8'h00;
      end else begin
         case (state)
            adcc_pkg::ADCC_IDLE: state <= adcc_pkg::ADCC_IDLE;
            adcc_pkg::ADCC_RESET: begin
               // Falling start after a high launches one conversion
               state <= pdn ? adcc_pkg::ADCC_IDLE
                            : adcc_pkg::ADCC_CONV;
               conv_cnt <= 8'h00;
            end
            adcc_pkg::ADCC_CONV: begin
               if (pdn) begin
                  state <= adcc_pkg::ADCC_IDLE;
               end else if (ck_en) begin
                  if (conv_cnt == 8'(CONV_LEN - 1)) begin
                     state <= adcc_pkg::ADCC_IDLE;
                  end
                  conv_cnt <= conv_cnt + 8'h01;
               end
            end
            default: state <= adcc_pkg::ADCC_IDLE;
         endcase
      end
   end

   // Powered-down abort leaves busy high, like an unfinished conversion
   logic busy_hold;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busy_hold <= adcc_pkg::CTRL_A_RST[adcc_pkg::CA_BUSY];
      end else if (start) begin
         busy_hold <= 1'b1;
      end else if (conv_done) begin
         busy_hold <= 1'b0;
      end
   end

   assign busy = busy_hold || state != adcc_pkg::ADCC_IDLE;
   assign conv_done = state == adcc_pkg::ADCC_CONV && !start && !pdn
      && ck_en && conv_cnt == 8'(CONV_LEN - 1);
   assign sample_take = conv_done;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         result <= 12'h000;
      end else if (conv_done) begin
         result <= sample_in;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt: set wins over a write-one clear
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_stat <= 1'b0;
      end else if (conv_done) begin
         irq_stat <= 1'b1;
      end else if (wr_reg(wr_hit, wb_adr_i, adcc_pkg::OFF_IRQ_STAT)
                   && wb_dat_i[0]) begin
         irq_stat <= 1'b0;
      end
   end
   assign irq = irq_stat && irq_mask;

   // ---------------------------------------------------------------
   // Analog controls
   // ---------------------------------------------------------------
   always_comb begin
      ana.chan = chan;
      ana.vref = ctrl_b[4:3];
      ana.clk_sel = ctrl_b[2:0];
      ana.pdn = pdn;
      // Needed when selected as input or reference, or by monitors
      ana.bg_on = (ctrl_b[adcc_pkg::CB_BGEN] && !pdn
         && (chan[4] || ctrl_b[4])) || lv_monitors_on;
   end

   always_comb begin
      analog_sel_onehot = 11'h000;
      if (ana.chan[4]) begin
         analog_sel_onehot[10] = 1'b1;
      end else if (ana.chan[3:0] == 4'h8) begin
         analog_sel_onehot[8] = 1'b1;
      end else if (ana.chan[3]) begin
         analog_sel_onehot[9] = 1'b1;
      end else begin
         analog_sel_onehot[ana.chan[2:0]] = 1'b1;
      end
   end

   always_comb begin
      if (ana.vref[1]) begin
         ref_sel_onehot = 3'b100;
      end else if (ana.vref[0]) begin
         ref_sel_onehot = 3'b010;
      end else begin
         ref_sel_onehot = 3'b001;
      end
   end

   assign input_channel_select = ana.chan;
   assign converter_power_down = ana.pdn;
   assign bandgap_on = ana.bg_on;
   assign conv_reset = start || ana.pdn;
   assign pin_analog_mode = {pin_sel_b, pin_sel_a};
   assign pin_pullup_off = {pin_sel_b, pin_sel_a};

   // ---------------------------------------------------------------
   // Result formatting and read mux
   // ---------------------------------------------------------------
   always_comb begin
      if (ctrl_b[adcc_pkg::CB_JUST]) begin
         res_low = result[7:0];
         res_high = {4'h0, result[11:8]};
      end else begin
         res_low = {result[3:0], 4'h0};
         res_high = result[11:4];
      end
   end

   // Read data latched when the request is taken, held until the next
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         case (wb_adr_i)
            adcc_pkg::OFF_RES_LOW: wb_dat_o <= {24'h0, res_low};
            adcc_pkg::OFF_RES_HIGH: wb_dat_o <= {24'h0, res_high};
            adcc_pkg::OFF_CTRL_A:
               wb_dat_o <= {24'h0, start, busy, pdn, chan};
            adcc_pkg::OFF_CTRL_B: wb_dat_o <= {24'h0, 1'b0, ctrl_b};
            adcc_pkg::OFF_PIN_SEL_A: wb_dat_o <= {24'h0, pin_sel_a};
            adcc_pkg::OFF_PIN_SEL_B: wb_dat_o <= {24'h0, pin_sel_b};
            adcc_pkg::OFF_IRQ_STAT: wb_dat_o <= {31'h0, irq_stat};
            adcc_pkg::OFF_IRQ_MASK: wb_dat_o <= {31'h0, irq_mask};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_start_busy: assert property (@(posedge sys_clk) disable iff (rst)
      start |-> conv_reset ##1 busy)
      else $error("busy not forced while start high");
   chk_done_result: assert property (@(posedge sys_clk) disable iff (rst)
      conv_done |=> result == $past(sample_in) && !busy)
      else $error("result not loaded at end");
   chk_done_irq: assert property (@(posedge sys_clk) disable iff (rst)
      conv_done |=> irq_stat)
      else $error("interrupt flag not set");
   chk_just_zero: assert property (@(posedge sys_clk) disable iff (rst)
      ctrl_b[adcc_pkg::CB_JUST] |-> res_high[7:4] == 4'h0)
      else $error("high nibble not zero");
   chk_left_zero: assert property (@(posedge sys_clk) disable iff (rst)
      !ctrl_b[adcc_pkg::CB_JUST] |-> res_low[3:0] == 4'h0
      && res_high == result[11:4])
      else $error("left format wrong");
   chk_just_right: assert property (@(posedge sys_clk) disable iff (rst)
      ctrl_b[adcc_pkg::CB_JUST] |-> res_low == result[7:0]
      && res_high[3:0] == result[11:8])
      else $error("right format wrong");
   chk_launch_conv: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(start) && !pdn |=> state == adcc_pkg::ADCC_CONV)
      else $error("no conversion after start pulse");
   chk_chan_bg: assert property (@(posedge sys_clk) disable iff (rst)
      chan[4] |-> analog_sel_onehot == 11'h400)
      else $error("bandgap not routed");
   chk_bg_off: assert property (@(posedge sys_clk) disable iff (rst)
      !ctrl_b[adcc_pkg::CB_BGEN] && !lv_monitors_on |-> !bandgap_on)
      else $error("bandgap on while unused");
   chk_bg_need: assert property (@(posedge sys_clk) disable iff (rst)
      ctrl_b[adcc_pkg::CB_BGEN] && !pdn && chan[4] |-> bandgap_on)
      else $error("bandgap off while routed");
   chk_ref_route: assert property (@(posedge sys_clk) disable iff (rst)
      $onehot(ref_sel_onehot) && ref_sel_onehot[2] == ctrl_b[4]
      && ref_sel_onehot[1] == (ctrl_b[4:3] == 2'h1))
      else $error("reference route wrong");
   chk_pdn_reset: assert property (@(posedge sys_clk) disable iff (rst)
      pdn && !start |-> converter_power_down && conv_reset
      ##1 state == adcc_pkg::ADCC_IDLE)
      else $error("power down not applied");
   chk_pin_write: assert property (@(posedge sys_clk) disable iff (rst)
      wr_reg(wr_hit, wb_adr_i, adcc_pkg::OFF_PIN_SEL_A)
      |=> pin_analog_mode[7:0] == $past(wb_dat_i[7:0])
      && pin_pullup_off[7:0] == $past(wb_dat_i[7:0]))
      else $error("pin select not applied");
   chk_clk_divide: assert property (@(posedge sys_clk) disable iff (rst)
      ck_en && ctrl_b[2:0] != 3'h0
      && !wr_reg(wr_hit, wb_adr_i, adcc_pkg::OFF_CTRL_B) |=> !ck_en)
      else $error("converter clock too fast");
   chk_take_pulse: assert property (@(posedge sys_clk) disable iff (rst)
      sample_take |-> !conv_reset && state == adcc_pkg::ADCC_CONV
      ##1 !sample_take)
      else $error("sample strobe misplaced");
   chk_ctrlb_top: assert property (@(posedge sys_clk) disable iff (rst)
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
      && wb_adr_i == adcc_pkg::OFF_CTRL_B |=> wb_dat_o[31:7] == 25'h0)
      else $error("control b top bit set");

   // ---------------------------------------------------------------
   // Coverage
   // ---------------------------------------------------------------
   cov_conv: cover property (@(posedge sys_clk) disable iff (rst) conv_done);
   cov_clear: cover property (@(posedge sys_clk) disable iff (rst)
      irq_stat ##1 !irq_stat);
   cov_sub: cover property (@(posedge sys_clk) disable iff (rst)
      conv_done && ctrl_b[2:0] == 3'h7);
   cov_irq_line: cover property (@(posedge sys_clk) disable iff (rst)
      irq);
   cov_bg_conv: cover property (@(posedge sys_clk) disable iff (rst)
      conv_done && chan[4]);
endmodule : adcc_top

// >>> sim/adcc_sensor_model.sv
// Purpose: Analog source model feeding the converter sample input
// Assumes: One routed source at a time, picked by the one-hot select
// Notes: Unrouted input toggles so a stale value never matches
`timescale 1ns/1ps
module adcc_sensor_model (
   input wire logic sys_clk, // System clock
   input wire logic [10:0] analog_sel_onehot, // Routed source
   output logic [11:0] sample_in // Converted level
);
   logic [11:0] idle_pat = 12'h3c5;

   always @(posedge sys_clk) begin
      idle_pat <= ~idle_pat;
   end

   // Each source has its own level, so a misroute shows in the result
   always_comb begin
      sample_in = idle_pat;
      for (int i = 0; i < 11; i++) begin
         if (analog_sel_onehot[i]) begin
            sample_in = {4'h5, 4'(i), 4'ha};
         end
      end
   end
endmodule : adcc_sensor_model

// >>> sim/test_adc_control_and_result_regs.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Wishbone answers one cycle after a request is taken
// Notes: Short conversion length keeps the run brief
`timescale 1ns/1ps
module test_adc_control_and_result_regs;
   localparam int CL = 3;
   localparam int BG_SETTLE = 20;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic lv_on = 1'b0;
   logic [31:0] rdat;
   logic ack, pdn_o, bg_o, creset, take, irq;
   logic [11:0] sample;
   logic [4:0] chan_o;
   logic [10:0] onehot;
   logic [2:0] ref_oh;
   logic [15:0] pin_an, pin_pu;
   logic [7:0] q;
   logic mask_on = 1'b0;
   int failures = 0;
   int cmp_count = 0;
   int takes = 0;

   always #2 sys_clk = ~sys_clk;

   // Counts converter sample strobes
   always @(posedge sys_clk) begin
      if (take === 1'b1) takes <= takes + 1;
   end

   adcc_top #(.CONV_LEN(CL)) i_dut (.sys_clk(sys_clk), .rst(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .sample_in(sample), .lv_monitors_on(lv_on),
      .input_channel_select(chan_o), .analog_sel_onehot(onehot),
      .ref_sel_onehot(ref_oh), .converter_power_down(pdn_o),
      .bandgap_on(bg_o), .conv_reset(creset), .sample_take(take),
      .pin_analog_mode(pin_an), .pin_pullup_off(pin_pu), .irq(irq));

   adcc_sensor_model i_src (.sys_clk(sys_clk), .analog_sel_onehot(onehot),
      .sample_in(sample));

   // ---------------------------------------------------------------
   // Bus and check helpers
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {24'h0, d};
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1);
      q = rdat[7:0];
      chk("bus ack", 32'h1, 32'(ack));
      // Taken one edge after the request, ack seen at the next
      chk("ack latency", 32'h2, 32'(n));
      // Write landed an edge ago, so outputs stand settled here
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [7:0] e, string nm);
      wb(a, 1'b0, 8'h00);
      chk(nm, 32'(e), 32'(q));
   endtask : rd

   task automatic close_out;
      if (failures == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      chk("power down out", 32'h1, 32'(pdn_o));
      rd(adcc_pkg::OFF_CTRL_A, 8'h60, "ctrl a reset");
      rd(adcc_pkg::OFF_CTRL_B, 8'h00, "ctrl b reset");
      wb(adcc_pkg::OFF_CTRL_B, 1'b1, 8'hff);
      rd(adcc_pkg::OFF_CTRL_B, 8'h7f, "ctrl b top bit");
      wb(adcc_pkg::OFF_CTRL_A, 1'b1, 8'h20);
      rd(adcc_pkg::OFF_CTRL_A, 8'h60, "busy write");
      wb(8'h20, 1'b1, 8'hff);
      rd(8'h20, 8'h00, "unmapped read");
   endtask : t_reset

   task automatic t_route;
      logic [10:0] e;
      for (int c = 0; c < 32; c++) begin
         wb(adcc_pkg::OFF_CTRL_A, 1'b1, {3'b001, 5'(c)});
         e = c < 8 ? 11'h1 << c : c == 8 ? 11'h100
             : c < 16 ? 11'h200 : 11'h400;
         chk("channel code", 32'(c), 32'(chan_o));
         chk("channel route", 32'(e), 32'(onehot));
      end
      for (int v = 0; v < 4; v++) begin
         wb(adcc_pkg::OFF_CTRL_B, 1'b1, {3'b000, 2'(v), 3'b000});
         chk("ref route", v == 0 ? 1 : v == 1 ? 2 : 4, 32'(ref_oh));
      end
   endtask : t_route

   task automatic t_pins;
      wb(adcc_pkg::OFF_PIN_SEL_A, 1'b1, 8'ha5);
      wb(adcc_pkg::OFF_PIN_SEL_B, 1'b1, 8'h3c);
      chk("pin analog", 32'h3ca5, 32'(pin_an));
      chk("pin pullup off", 32'h3ca5, 32'(pin_pu));
      wb(adcc_pkg::OFF_PIN_SEL_A, 1'b1, 8'h00);
      chk("pin restored", 32'h3c00, 32'(pin_pu));
   endtask : t_pins

   task automatic t_bandgap;
      wb(adcc_pkg::OFF_CTRL_A, 1'b1, 8'h20);
      wb(adcc_pkg::OFF_CTRL_B, 1'b1, 8'h00);
      chk("bandgap idle", 32'h0, 32'(bg_o));
      lv_on <= 1'b1;
      @(posedge sys_clk);
      chk("bandgap monitors", 32'h1, 32'(bg_o));
      lv_on <= 1'b0;
      wb(adcc_pkg::OFF_CTRL_B, 1'b1, 8'h40);
      wb(adcc_pkg::OFF_CTRL_A, 1'b1, 8'h10);
      chk("bandgap channel", 32'h1, 32'(bg_o));
      wb(adcc_pkg::OFF_CTRL_A, 1'b1, 8'h00);
      chk("bandgap unused", 32'h0, 32'(bg_o));
      wb(adcc_pkg::OFF_CTRL_B, 1'b1, 8'h58);
      chk("bandgap as ref", 32'h1, 32'(bg_o));
      wb(adcc_pkg::OFF_CTRL_B, 1'b1, 8'h18);
      chk("bandgap disabled", 32'h0, 32'(bg_o));
   endtask : t_bandgap

   task automatic conv(input logic [4:0] ch, input logic [2:0] ck);
      logic [11:0] v;
      int n;
      int div;
      int t0;
      v = ch[4] ? 12'h5aa : ch == 8 ? 12'h58a : ch > 8 ? 12'h59a
          : {4'h5, 1'b0, ch[2:0], 4'ha};
      div = ck == 7 ? adcc_pkg::SUB_DIV : 1 << ck;
      n = 0;
      t0 = takes;
      wb(adcc_pkg::OFF_CTRL_B, 1'b1, {1'b0, ch[4], 3'b000, ck});
      wb(adcc_pkg::OFF_CTRL_A, 1'b1, {3'b000, ch});
      if (ch[4]) repeat (BG_SETTLE) @(posedge sys_clk);
      wb(adcc_pkg::OFF_CTRL_A, 1'b1, {3'b100, ch});
      rd(adcc_pkg::OFF_CTRL_A, {3'b110, ch}, "busy start held");
      chk("conv reset held", 32'h1, 32'(creset));
      wb(adcc_pkg::OFF_CTRL_A, 1'b1, {3'b000, ch});
      do begin
         wb(adcc_pkg::OFF_CTRL_A, 1'b0, 8'h00);
         n++;
      end while (q[6] !== 1'b0 && n < 200);
      chk("conv reset off", 32'h0, 32'(creset));
      chk("sample strobes", 32'h1, 32'(takes - t0));
      chk("conv length", 32'h1, 32'(3 * n <= CL * div + div + 12));
      if (ck > 1) chk("busy in conv", 32'h1, 32'(n > 1));
      rd(adcc_pkg::OFF_RES_HIGH, v[11:4], "result high j0");
      rd(adcc_pkg::OFF_RES_LOW, {v[3:0], 4'h0}, "result low j0");
      wb(adcc_pkg::OFF_CTRL_B, 1'b1, {1'b0, ch[4], 3'b100, ck});
      rd(adcc_pkg::OFF_RES_HIGH, {4'h0, v[11:8]}, "result high j1");
      rd(adcc_pkg::OFF_RES_LOW, v[7:0], "result low j1");
      rd(adcc_pkg::OFF_IRQ_STAT, 8'h01, "done flag");
      chk("irq level", 32'(mask_on), 32'(irq));
      wb(adcc_pkg::OFF_IRQ_STAT, 1'b1, 8'h01);
      rd(adcc_pkg::OFF_IRQ_STAT, 8'h00, "done flag cleared");
      chk("irq cleared", 32'h0, 32'(irq));
   endtask : conv

   task automatic t_conv;
      for (int k = 0; k < 8; k++) begin
         conv(5'(k), 3'(k));
      end
      conv(5'h08, 3'h0);
      conv(5'h0c, 3'h1);
      conv(5'h13, 3'h0);
      mask_on = 1'b1;
      wb(adcc_pkg::OFF_IRQ_MASK, 1'b1, 8'h01);
      conv(5'h05, 3'h2);
      mask_on = 1'b0;
      wb(adcc_pkg::OFF_IRQ_MASK, 1'b1, 8'h00);
      wb(adcc_pkg::OFF_CTRL_A, 1'b1, 8'h20);
      chk("powered down", 32'h1, 32'(pdn_o));
      chk("off holds reset", 32'h1, 32'(creset));
   endtask : t_conv

   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset;
      t_route;
      t_pins;
      t_bandgap;
      t_conv;
      close_out;
   end

   // Generous bound: the whole run needs under two thousand cycles
   initial begin
      #200000;
      failures++;
      close_out;
   end
endmodule : test_adc_control_and_result_regs
